// ===== logic/idbp_consts.svh
`ifndef IDBP_CONSTS_SVH
`define IDBP_CONSTS_SVH

// paging register offsets from the i/o base
`define IDBP_OFS_BANK 10'h000
`define IDBP_OFS_SOCK 10'h001

// i/o base per switch code {high, low}
`define IDBP_IO_BASE0 10'h220
`define IDBP_IO_BASE1 10'h2A0
`define IDBP_IO_BASE2 10'h320
`define IDBP_IO_BASE3 10'h3A0

// window segment per switch code {high, low}
`define IDBP_WIN_SEG0 16'hCC00
`define IDBP_WIN_SEG1 16'hD000
`define IDBP_WIN_SEG2 16'hD400
`define IDBP_WIN_SEG3 16'hD800

// second card sits one step above the first
`define IDBP_CARD_IO_STEP 10'h080
`define IDBP_CARD_SEG_STEP 16'h0400

// register fields and reset values
`define IDBP_WPE_BIT 7
`define IDBP_SOCK_PATTERN 4'h1
`define IDBP_BANK_RST 8'h00
`define IDBP_SOCK_RST 4'h0
`define IDBP_OFS_W 13
`define IDBP_CARD_SOCKETS 8

// isa strobe length
`define IDBP_CLK_MHZ 25
`define IDBP_STROBE_NS 200
`define IDBP_STROBE_CYC ((`IDBP_STROBE_NS * `IDBP_CLK_MHZ + 999) / 1000)

// host apb register offsets
`define IDBP_APB_CTRL 8'h00
`define IDBP_APB_CFG 8'h04
`define IDBP_APB_TARGET 8'h08
`define IDBP_APB_WDATA 8'h0C
`define IDBP_APB_STATUS 8'h10

// host operation codes
`define IDBP_OP_PAGE 2'h0
`define IDBP_OP_READ 2'h1
`define IDBP_OP_WRITE 2'h2

`endif

// ===== logic/idbp_pkg.sv
`default_nettype none

package idbp_pkg;

    typedef enum logic [2:0] {
        IDBP_K64 = 3'b000,
        IDBP_K128 = 3'b001,
        IDBP_K256 = 3'b010,
        IDBP_K512 = 3'b011,
        IDBP_K1M = 3'b100,
        IDBP_S128 = 3'b101,
        IDBP_S512 = 3'b110
    } idbp_kind_t;

    typedef enum logic [1:0] {
        IDBP_IDLE = 2'b00,
        IDBP_SETUP = 2'b01,
        IDBP_STROBE = 2'b10,
        IDBP_RECOVER = 2'b11
    } idbp_hstate_t;

    typedef logic [6:0] idbp_field_t;

endpackage

`default_nettype wire

// ===== logic/idbp_isa_if.sv
`timescale 1ns/10ps
`default_nettype none

interface idbp_isa_if;
    logic [19:0] sa;
    logic [7:0] sd_host;
    logic host_oe_n;
    logic [7:0] sd_dev;
    logic dev_oe_n;
    logic [7:0] sd;
    logic ior_n;
    logic iow_n;
    logic memr_n;
    logic memw_n;

    // resolved data bus, pulled high when nobody drives
    assign sd = !dev_oe_n ? sd_dev : (!host_oe_n ? sd_host : 8'hFF);

    modport disk (
        input sa, sd, ior_n, iow_n, memr_n, memw_n,
        output sd_dev, dev_oe_n
    );

    modport host (
        output sa, sd_host, host_oe_n, ior_n, iow_n, memr_n, memw_n,
        input sd
    );
endinterface

`default_nettype wire

// ===== logic/idbp_disk_end.sv
// Behaviour
// - memory cut into 8 KB banks, one shown
// - bank numbers start at zero per chip
// - bank register base+0, socket register base+1
// - switches pick i/o base and window
// - bank register: bit 7 protect, 6..0 field
// - socket register: pattern 0001, index 3..0
// - eprom/flash bank bit placement by size
// - sram bank bit placement by size
// - bank bit count is log2 of banks
// - two cards, contiguous bases and windows
// - only the listed two-card pairings allowed
// - eight sockets per card plus one module
// - images fill first card, module, second card
`timescale 1ns/10ps
`default_nettype none

`include "idbp_consts.svh"

module idbp_disk_end #(
    parameter int SOCKETS = 16
) (
    // clock and reset
    input wire logic CLK_SYS_I,
    input wire logic NRST_I,
    // configuration switches
    input wire logic IO_BASE_SWITCH_LOW_I,
    input wire logic IO_BASE_SWITCH_HIGH_I,
    input wire logic WINDOW_SWITCH_LOW_I,
    input wire logic WINDOW_SWITCH_HIGH_I,
    input wire logic PIGGYBACK_CONNECTOR_I,
    // isa link
    idbp_isa_if.disk ISA,
    // memory sockets
    output logic [SOCKETS-1:0] SOCKET_CE_N_O,
    output logic [19:0] MEM_ADDR_O,
    output logic MEM_OE_N_O,
    output logic MEM_WE_N_O,
    output logic [7:0] MEM_DATA_O,
    input wire logic [7:0] MEM_DATA_I,
    // paging state
    output idbp_pkg::idbp_field_t BANK_FIELD_BITS_O,
    output logic WRITE_PROTECT_ENABLE_FLAG_O,
    output logic [3:0] SOCKET_INDEX_BITS_O,
    output logic WRITE_BLOCKED_O
);
    import idbp_pkg::*;

    generate
        if (SOCKETS != `IDBP_CARD_SOCKETS && SOCKETS != 2 * `IDBP_CARD_SOCKETS) begin : g_chk
            $error("SOCKETS must be 8 or 16");
        end
    endgenerate

    logic [9:0] io_base;
    logic [15:0] win_seg;
    logic hit_bank;
    logic hit_sock;
    logic win_hit;
    logic sock_ok;
    logic mem_rd;
    logic mem_wr;
    logic iow_fall;
    logic memw_fall;
    logic iow_n_q;
    logic memw_n_q;
    logic [7:0] bank_q;
    logic [3:0] sock_q;
    logic [SOCKETS-1:0] ce_n_q;
    logic [19:0] addr_q;
    logic oe_n_q;
    logic we_n_q;
    logic [7:0] mdata_q;
    logic blocked_q;
    logic [7:0] sd_dev_q;
    logic dev_oe_n_q;

    // i/o base from the two base switches
    always_comb begin
        if ({IO_BASE_SWITCH_HIGH_I, IO_BASE_SWITCH_LOW_I} == 2'b00) begin
            io_base = `IDBP_IO_BASE0;
        end else if ({IO_BASE_SWITCH_HIGH_I, IO_BASE_SWITCH_LOW_I} == 2'b01) begin
            io_base = `IDBP_IO_BASE1;
        end else if ({IO_BASE_SWITCH_HIGH_I, IO_BASE_SWITCH_LOW_I} == 2'b10) begin
            io_base = `IDBP_IO_BASE2;
        end else begin
            io_base = `IDBP_IO_BASE3;
        end
    end

    // window segment from the two window switches
    always_comb begin
        if ({WINDOW_SWITCH_HIGH_I, WINDOW_SWITCH_LOW_I} == 2'b00) begin
            win_seg = `IDBP_WIN_SEG0;
        end else if ({WINDOW_SWITCH_HIGH_I, WINDOW_SWITCH_LOW_I} == 2'b01) begin
            win_seg = `IDBP_WIN_SEG1;
        end else if ({WINDOW_SWITCH_HIGH_I, WINDOW_SWITCH_LOW_I} == 2'b10) begin
            win_seg = `IDBP_WIN_SEG2;
        end else begin
            win_seg = `IDBP_WIN_SEG3;
        end
    end

    // register and window decode
    always_comb begin
        hit_bank = (ISA.sa[9:0] == io_base + `IDBP_OFS_BANK);
        hit_sock = (ISA.sa[9:0] == io_base + `IDBP_OFS_SOCK);
        win_hit = (ISA.sa[19:`IDBP_OFS_W] == win_seg[15:`IDBP_OFS_W-4]);
        // sockets 8..15 exist only on a fitted module
        sock_ok = !sock_q[3] || (SOCKETS > `IDBP_CARD_SOCKETS && PIGGYBACK_CONNECTOR_I);
        mem_rd = !ISA.memr_n && win_hit && sock_ok;
        mem_wr = !ISA.memw_n && win_hit && sock_ok;
        iow_fall = !ISA.iow_n && iow_n_q;
        memw_fall = !ISA.memw_n && memw_n_q;
    end

    // strobe history for edge detection
    always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
        if (!NRST_I) begin
            iow_n_q <= 1'b1;
            memw_n_q <= 1'b1;
        end else begin
            iow_n_q <= ISA.iow_n;
            memw_n_q <= ISA.memw_n;
        end
    end

    // bank register, whole byte stored
    always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
        if (!NRST_I) begin
            bank_q <= `IDBP_BANK_RST;
        end else if (iow_fall && hit_bank) begin
            bank_q <= ISA.sd;
        end
    end

    // socket register, taken only with the fixed upper pattern
    always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
        if (!NRST_I) begin
            sock_q <= `IDBP_SOCK_RST;
        end else if (iow_fall && hit_sock && ISA.sd[7:4] == `IDBP_SOCK_PATTERN) begin
            sock_q <= ISA.sd[3:0];
        end
    end

    // one chip enable for the selected socket
    always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
        if (!NRST_I) begin
            ce_n_q <= '1;
        end else begin
            for (int i = 0; i < SOCKETS; i++) begin
                ce_n_q[i] <= !((mem_rd || mem_wr) && sock_q == 4'(i));
            end
        end
    end

    // socket address: bank field above the 13-bit offset
    always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
        if (!NRST_I) begin
            addr_q <= 20'h00000;
        end else begin
            addr_q <= {bank_q[6:0], ISA.sa[`IDBP_OFS_W-1:0]};
        end
    end

    // memory read and write strobes
    always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
        if (!NRST_I) begin
            oe_n_q <= 1'b1;
            we_n_q <= 1'b1;
        end else begin
            oe_n_q <= !mem_rd;
            we_n_q <= !(mem_wr && !bank_q[`IDBP_WPE_BIT]);
        end
    end

    // write data toward the sockets
    always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
        if (!NRST_I) begin
            mdata_q <= 8'h00;
        end else begin
            mdata_q <= ISA.sd;
        end
    end

    // one-cycle pulse for each refused window write
    always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
        if (!NRST_I) begin
            blocked_q <= 1'b0;
        end else begin
            blocked_q <= memw_fall && win_hit && sock_ok && bank_q[`IDBP_WPE_BIT];
        end
    end

    // read data back onto the isa bus
    always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
        if (!NRST_I) begin
            sd_dev_q <= 8'h00;
            dev_oe_n_q <= 1'b1;
        end else begin
            dev_oe_n_q <= !((!ISA.ior_n && (hit_bank || hit_sock)) || mem_rd);
            if (!ISA.ior_n && hit_bank) begin
                sd_dev_q <= bank_q;
            end else if (!ISA.ior_n && hit_sock) begin
                sd_dev_q <= {`IDBP_SOCK_PATTERN, sock_q};
            end else begin
                sd_dev_q <= MEM_DATA_I;
            end
        end
    end

    assign ISA.sd_dev = sd_dev_q;
    assign ISA.dev_oe_n = dev_oe_n_q;
    assign SOCKET_CE_N_O = ce_n_q;
    assign MEM_ADDR_O = addr_q;
    assign MEM_OE_N_O = oe_n_q;
    assign MEM_WE_N_O = we_n_q;
    assign MEM_DATA_O = mdata_q;
    assign BANK_FIELD_BITS_O = bank_q[6:0];
    assign WRITE_PROTECT_ENABLE_FLAG_O = bank_q[`IDBP_WPE_BIT];
    assign SOCKET_INDEX_BITS_O = sock_q;
    assign WRITE_BLOCKED_O = blocked_q;

endmodule // idbp_disk_end

`default_nettype wire

// ===== logic/idbp_host_end.sv
// Register access over APB was left to the implementer.
`timescale 1ns/10ps
`default_nettype none

`include "idbp_consts.svh"

module idbp_host_end #(
    parameter int STROBE_CYC = `IDBP_STROBE_CYC
) (
    // clock and reset
    input wire logic CLK_SYS_I,
    input wire logic NRST_I,
    // apb slave
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    // isa link
    idbp_isa_if.host ISA,
    // status
    output idbp_pkg::idbp_hstate_t STATE_O
);
    import idbp_pkg::*;

    generate
        if (STROBE_CYC < 3 || STROBE_CYC > 7) begin : g_chk
            $error("STROBE_CYC must be 3 to 7");
        end
    endgenerate

    idbp_hstate_t st_q;
    logic [10:0] cfg_q;
    logic [24:0] tgt_q;
    logic [7:0] wdata_q;
    logic [7:0] rdata_q;
    logic busy_q, done_q, err_q;
    logic [1:0] op_q, step_q;
    logic [2:0] cnt_q;
    logic [9:0] io_q;
    logic [6:0] win_q;
    logic [7:0] bankv_q, sockv_q;
    logic [31:0] prdata_q;
    logic [19:0] sa_q;
    logic [7:0] sd_q;
    logic hoe_n_q, ior_n_q, iow_n_q, memr_n_q, memw_n_q;
    logic acc, wr, go, mapped, card1, bad;
    logic [3:0] idx;
    logic [6:0] b, mask, field;
    logic [9:0] base0;
    logic [15:0] seg0, seg;

    always_comb begin
        acc = PSEL_I && PENABLE_I;
        wr = acc && PWRITE_I;
        mapped = PADDR_I == `IDBP_APB_CTRL || PADDR_I == `IDBP_APB_CFG ||
                 PADDR_I == `IDBP_APB_TARGET || PADDR_I == `IDBP_APB_WDATA ||
                 PADDR_I == `IDBP_APB_STATUS;
        go = wr && PADDR_I == `IDBP_APB_CTRL && PWDATA_I[0] && st_q == IDBP_IDLE;
        b = tgt_q[19:13];
        // field placement and bank count per part kind
        case (idbp_kind_t'(cfg_q[2:0]))
            IDBP_K64: begin field = {4'b0010, b[2:0]}; mask = 7'h07; end
            IDBP_K128: begin field = {3'b001, b[3:0]}; mask = 7'h0F; end
            IDBP_K256: begin field = {1'b0, b[4], 1'b1, b[3:0]}; mask = 7'h1F; end
            IDBP_K512: begin field = {1'b0, b[4], b[5], b[3:0]}; mask = 7'h3F; end
            IDBP_K1M: begin field = {b[6], b[4], b[5], b[3:0]}; mask = 7'h7F; end
            IDBP_S128: begin field = {3'b010, b[3:0]}; mask = 7'h0F; end
            IDBP_S512: begin field = {1'b0, b[5:0]}; mask = 7'h3F; end
            default: begin field = 7'h00; mask = 7'h00; end
        endcase
        // image order: first card, its module, second card, its module
        card1 = 1'b0;
        idx = {1'b0, tgt_q[22:20]};
        bad = (b & ~mask) != 7'h00 || cfg_q[2:0] == 3'b111;
        case (tgt_q[24:23])
            2'b00: idx[3] = 1'b0;
            2'b01: begin idx[3] = cfg_q[4]; card1 = !cfg_q[4]; end
            2'b10: begin card1 = 1'b1; bad = bad || !cfg_q[4]; end
            default: begin idx[3] = 1'b1; card1 = 1'b1; bad = bad || !cfg_q[4] || !cfg_q[5]; end
        endcase
        bad = bad || (cfg_q[5] && !cfg_q[4]);
        case (cfg_q[7:6])
            2'b00: base0 = `IDBP_IO_BASE0;
            2'b01: base0 = `IDBP_IO_BASE1;
            2'b10: base0 = `IDBP_IO_BASE2;
            default: base0 = `IDBP_IO_BASE3;
        endcase
        case (cfg_q[9:8])
            2'b00: seg0 = `IDBP_WIN_SEG0;
            2'b01: seg0 = `IDBP_WIN_SEG1;
            2'b10: seg0 = `IDBP_WIN_SEG2;
            default: seg0 = `IDBP_WIN_SEG3;
        endcase
        // second card one base and one window above the first
        bad = bad || (card1 && (cfg_q[7:6] == 2'b11 || cfg_q[9:8] == 2'b11));
        seg = card1 ? seg0 + `IDBP_CARD_SEG_STEP : seg0;
    end

    // apb registers
    always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
        if (!NRST_I) begin
            cfg_q <= 11'h000;
            tgt_q <= 25'h0000000;
            wdata_q <= 8'h00;
        end else if (wr && PADDR_I == `IDBP_APB_CFG) begin
            cfg_q <= PWDATA_I[10:0];
        end else if (wr && PADDR_I == `IDBP_APB_TARGET) begin
            tgt_q <= PWDATA_I[24:0];
        end else if (wr && PADDR_I == `IDBP_APB_WDATA) begin
            wdata_q <= PWDATA_I[7:0];
        end
    end

    // read data prepared in the setup cycle
    always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
        if (!NRST_I) begin
            prdata_q <= 32'h00000000;
        end else if (PSEL_I && !PENABLE_I) begin
            if (PADDR_I == `IDBP_APB_CFG) begin
                prdata_q <= {21'h000000, cfg_q};
            end else if (PADDR_I == `IDBP_APB_TARGET) begin
                prdata_q <= {7'h00, tgt_q};
            end else if (PADDR_I == `IDBP_APB_WDATA) begin
                prdata_q <= {24'h000000, wdata_q};
            end else if (PADDR_I == `IDBP_APB_STATUS) begin
                prdata_q <= {16'h0000, rdata_q, 5'h00, err_q, done_q, busy_q};
            end else begin
                prdata_q <= 32'h00000000;
            end
        end
    end

    // paging sequence: bank write, socket write, optional window access
    always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
        if (!NRST_I) begin
            st_q <= IDBP_IDLE;
            {busy_q, done_q, err_q} <= 3'b000;
            {op_q, step_q, cnt_q} <= 7'h00;
            {io_q, win_q, bankv_q, sockv_q, rdata_q} <= 41'h00000000000;
            {sa_q, sd_q} <= 28'h0000000;
            {hoe_n_q, ior_n_q, iow_n_q, memr_n_q, memw_n_q} <= 5'h1F;
        end else begin
            case (st_q)
                IDBP_IDLE: begin
                    if (go) begin
                        done_q <= bad;
                        err_q <= bad;
                        busy_q <= !bad;
                        st_q <= bad ? IDBP_IDLE : IDBP_SETUP;
                        op_q <= PWDATA_I[2:1];
                        step_q <= 2'h0;
                        io_q <= card1 ? base0 + `IDBP_CARD_IO_STEP : base0;
                        win_q <= seg[15:9];
                        bankv_q <= {cfg_q[3], field};
                        sockv_q <= {`IDBP_SOCK_PATTERN, idx};
                    end
                end
                IDBP_SETUP: begin
                    cnt_q <= 3'h0;
                    st_q <= IDBP_STROBE;
                    iow_n_q <= step_q == 2'h2;
                    memr_n_q <= !(step_q == 2'h2 && op_q == `IDBP_OP_READ);
                    memw_n_q <= !(step_q == 2'h2 && op_q == `IDBP_OP_WRITE);
                end
                IDBP_STROBE: begin
                    cnt_q <= cnt_q + 3'h1;
                    if (cnt_q == 3'(STROBE_CYC - 1)) begin
                        if (!memr_n_q) begin
                            rdata_q <= ISA.sd;
                        end
                        {iow_n_q, memr_n_q, memw_n_q} <= 3'b111;
                        st_q <= IDBP_RECOVER;
                    end
                end
                default: begin
                    hoe_n_q <= 1'b1;
                    if (step_q == 2'h2 || (step_q == 2'h1 && op_q == `IDBP_OP_PAGE)) begin
                        busy_q <= 1'b0;
                        done_q <= 1'b1;
                        st_q <= IDBP_IDLE;
                    end else begin
                        step_q <= step_q + 2'h1;
                        st_q <= IDBP_SETUP;
                    end
                end
            endcase
            // address and data for the step about to start
            if (st_q == IDBP_RECOVER || (st_q == IDBP_IDLE && go && !bad)) begin
                if (st_q == IDBP_IDLE) begin
                    sa_q <= {10'h000, (card1 ? base0 + `IDBP_CARD_IO_STEP : base0)};
                    sd_q <= {cfg_q[3], field};
                    hoe_n_q <= 1'b0;
                end else if (step_q == 2'h0) begin
                    sa_q <= {10'h000, io_q + `IDBP_OFS_SOCK};
                    sd_q <= sockv_q;
                    hoe_n_q <= 1'b0;
                end else if (step_q == 2'h1 && op_q != `IDBP_OP_PAGE) begin
                    sa_q <= {win_q, tgt_q[12:0]};
                    sd_q <= wdata_q;
                    hoe_n_q <= op_q != `IDBP_OP_WRITE;
                end
            end
        end
    end

    assign PRDATA_O = prdata_q;
    assign PREADY_O = 1'b1;
    assign PSLVERR_O = acc && !mapped;
    assign ISA.sa = sa_q;
    assign ISA.sd_host = sd_q;
    assign ISA.host_oe_n = hoe_n_q;
    assign ISA.ior_n = ior_n_q;
    assign ISA.iow_n = iow_n_q;
    assign ISA.memr_n = memr_n_q;
    assign ISA.memw_n = memw_n_q;
    assign STATE_O = st_q;

endmodule // idbp_host_end

`default_nettype wire

// ===== verification/idbp_isa_asserts.sv
`timescale 1ns/10ps
`default_nettype none

module idbp_isa_asserts (
    // clock and reset
    input wire logic CLK_SYS_I,
    input wire logic NRST_I,
    // isa link
    input wire logic [19:0] sa,
    input wire logic [7:0] sd,
    input wire logic host_oe_n,
    input wire logic dev_oe_n,
    input wire logic ior_n,
    input wire logic iow_n,
    input wire logic memr_n,
    input wire logic memw_n
);
    default clocking cb @(posedge CLK_SYS_I);
    endclocking
    default disable iff (!NRST_I);

    // socket write follows bank write after recover and setup
    sequence sock_step;
        ##2 (!iow_n && sa[0]);
    endsequence

    io_strobe_len_a: assert property ($fell(iow_n) |-> (!iow_n)[*5] ##1 iow_n)
        else $error("io write strobe length wrong");
    rd_strobe_len_a: assert property ($fell(memr_n) |-> (!memr_n)[*5] ##1 memr_n)
        else $error("window read strobe length wrong");
    wr_strobe_len_a: assert property ($fell(memw_n) |-> (!memw_n)[*5] ##1 memw_n)
        else $error("window write strobe length wrong");
    sock_pattern_a: assert property (!iow_n && sa[0] |-> sd[7:4] == 4'h1)
        else $error("socket byte pattern wrong");
    io_base_set_a: assert property (!iow_n |-> sa[19:10] == 10'h000 &&
        sa[9:1] inside {9'h110, 9'h150, 9'h190, 9'h1D0})
        else $error("io address outside base set");
    win_range_a: assert property (!(memr_n && memw_n) |->
        sa[19:13] inside {7'h66, 7'h68, 7'h6A, 7'h6C})
        else $error("window address outside range");
    io_hold_a: assert property (!iow_n && !$past(iow_n) |-> $stable(sa) && $stable(sd))
        else $error("io address or data moved in strobe");
    bank_then_sock_a: assert property ($rose(iow_n) && !sa[0] |-> sock_step)
        else $error("socket write missing after bank write");
    dev_answer_a: assert property ($fell(dev_oe_n) |-> !$past(memr_n))
        else $error("disk drove data without read");
    no_clash_a: assert property (!(!dev_oe_n && !host_oe_n))
        else $error("both ends drive data");
    strobe_excl_a: assert property ($onehot0({!ior_n, !iow_n, !memr_n, !memw_n}))
        else $error("two strobes at once");
endmodule // idbp_isa_asserts

`default_nettype wire

// ===== verification/isa_disk_bank_paging_tb.sv
`timescale 1ns/10ps
`default_nettype none

`include "idbp_consts.svh"

module isa_disk_bank_paging_tb;
    import idbp_pkg::*;
    logic CLK_SYS_I = 1'b0;
    logic NRST_I = 1'b0;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, perr, write_protect_enable_flag, blocked, mem_oe_n, mem_we_n;
    logic [3:0] sw = 4'h0;
    logic piggy = 1'b0;
    logic [7:0] mem_di = 8'h00;
    logic [7:0] mem_do;
    logic [7:0] seen_wd;
    logic [15:0] ce_n, seen_ce;
    logic [19:0] mem_addr, seen_addr;
    logic [3:0] sidx;
    idbp_field_t field;
    idbp_hstate_t state;
    int mismatches = 0;
    int comparisons = 0;
    int cyc = 0;
    int n_we = 0;
    int n_blk = 0;

    always #20 CLK_SYS_I = ~CLK_SYS_I;

    idbp_isa_if idbp_isa_if_i ();
    idbp_host_end idbp_host_end_i (.CLK_SYS_I(CLK_SYS_I), .NRST_I(NRST_I), .PSEL_I(psel),
        .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .ISA(idbp_isa_if_i),
        .STATE_O(state));
    idbp_disk_end idbp_disk_end_i (.CLK_SYS_I(CLK_SYS_I), .NRST_I(NRST_I),
        .IO_BASE_SWITCH_LOW_I(sw[0]), .IO_BASE_SWITCH_HIGH_I(sw[1]),
        .WINDOW_SWITCH_LOW_I(sw[2]), .WINDOW_SWITCH_HIGH_I(sw[3]),
        .PIGGYBACK_CONNECTOR_I(piggy), .ISA(idbp_isa_if_i), .SOCKET_CE_N_O(ce_n),
        .MEM_ADDR_O(mem_addr), .MEM_OE_N_O(mem_oe_n), .MEM_WE_N_O(mem_we_n),
        .MEM_DATA_O(mem_do), .MEM_DATA_I(mem_di), .BANK_FIELD_BITS_O(field),
        .WRITE_PROTECT_ENABLE_FLAG_O(write_protect_enable_flag), .SOCKET_INDEX_BITS_O(sidx),
        .WRITE_BLOCKED_O(blocked));
    idbp_isa_asserts idbp_isa_asserts_i (.CLK_SYS_I(CLK_SYS_I), .NRST_I(NRST_I),
        .sa(idbp_isa_if_i.sa), .sd(idbp_isa_if_i.sd), .host_oe_n(idbp_isa_if_i.host_oe_n),
        .dev_oe_n(idbp_isa_if_i.dev_oe_n), .ior_n(idbp_isa_if_i.ior_n),
        .iow_n(idbp_isa_if_i.iow_n), .memr_n(idbp_isa_if_i.memr_n),
        .memw_n(idbp_isa_if_i.memw_n));

    // watches the memory side and cuts a hang short
    always @(posedge CLK_SYS_I) begin
        cyc <= cyc + 1;
        if (mem_oe_n === 1'b0) begin
            seen_addr <= mem_addr;
            seen_ce <= ce_n;
        end
        if (mem_we_n === 1'b0) begin
            n_we <= n_we + 1;
            seen_wd <= mem_do;
        end
        if (blocked === 1'b1) begin
            n_blk <= n_blk + 1;
        end
        if (cyc == 30000) begin
            mismatches++;
            final_report();
        end
    end

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r);
        @(posedge CLK_SYS_I);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge CLK_SYS_I);
        pen <= 1'b1;
        do begin
            @(posedge CLK_SYS_I);
        end while (pready !== 1'b1);
        r = prdata;
        perr = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    task automatic cmd(input logic [31:0] cfg, input logic [31:0] tgt, input logic [1:0] op,
        input logic [7:0] wd, output logic [31:0] st);
        apb(1'b1, `IDBP_APB_CFG, cfg, st);
        apb(1'b1, `IDBP_APB_TARGET, tgt, st);
        apb(1'b1, `IDBP_APB_WDATA, {24'h0, wd}, st);
        apb(1'b1, `IDBP_APB_CTRL, {29'h0, op, 1'b1}, st);
        do begin
            apb(1'b0, `IDBP_APB_STATUS, 32'h0, st);
        end while (st[1] !== 1'b1);
    endtask

    function automatic idbp_field_t fexp(input logic [2:0] k, input logic [6:0] b);
        case (k)
            3'h0: return {4'h2, b[2:0]};
            3'h1: return {3'h1, b[3:0]};
            3'h2: return {1'b0, b[4], 1'b1, b[3:0]};
            3'h3: return {1'b0, b[4], b[5], b[3:0]};
            3'h4: return {b[6], b[4], b[5], b[3:0]};
            3'h5: return {3'h2, b[3:0]};
            default: return {1'b0, b[5], b[4], b[3:0]};
        endcase
    endfunction

    task automatic t_reset();
        logic [31:0] r;
        apb(1'b0, `IDBP_APB_STATUS, 32'h0, r);
        chk(r, 32'h0);
        chk({field, write_protect_enable_flag, sidx}, 32'h0);
        chk(ce_n, 32'hFFFF);
        chk(state, IDBP_IDLE);
    endtask

    task automatic t_kinds();
        logic [31:0] st;
        logic [6:0] b;
        int nb[7] = '{3, 4, 5, 6, 7, 4, 6};
        for (int k = 0; k < 7; k++) begin
            @(posedge CLK_SYS_I);
            sw <= {2{k[1:0]}};
            b = 7'((1 << nb[k]) - 1);
            cmd({22'h0, k[1:0], k[1:0], 2'h0, k[0], k[2:0]}, {7'h0, 5'(k), b, 13'h0ABC},
                `IDBP_OP_PAGE, 8'h00, st);
            chk(st[2], 1'b0);
            chk(field, fexp(k[2:0], b));
            chk(write_protect_enable_flag, k[0]);
            chk(sidx, 4'(k));
        end
    endtask

    task automatic t_read(input logic [3:0] s, input logic p, input logic [4:0] img,
        input logic [3:0] idx, input logic [7:0] d);
        logic [31:0] st;
        @(posedge CLK_SYS_I);
        sw <= s;
        piggy <= p;
        mem_di <= d;
        cmd({27'h0, p, 4'h2}, {7'h0, img, 7'h09, 13'h1234}, `IDBP_OP_READ, 8'h00, st);
        chk(st[15:8], d);
        chk(sidx, idx);
        chk(seen_addr, {7'h19, 13'h1234});
        chk(seen_ce, {16'h0000, ~(16'h0001 << idx)});
    endtask

    task automatic t_protect();
        logic [31:0] st;
        int blk0, we0;
        @(posedge CLK_SYS_I);
        sw <= 4'h0;
        blk0 = n_blk;
        we0 = n_we;
        cmd(32'hD, {19'h0, 13'h0042}, `IDBP_OP_WRITE, 8'hA5, st);
        chk(n_blk - blk0, 1);
        chk(n_we - we0, 0);
        cmd(32'h5, {19'h0, 13'h0042}, `IDBP_OP_WRITE, 8'h5A, st);
        chk(state, IDBP_IDLE);
        chk(n_we > we0, 1'b1);
        chk(seen_wd, 8'h5A);
    endtask

    task automatic t_errors();
        logic [31:0] st;
        logic [31:0] cfgs[5] = '{32'h1, 32'h7, 32'hC0, 32'h300, 32'h20};
        logic [31:0] tgts[5] = '{32'h20000, 32'h0, 32'h800000, 32'h800000, 32'h1800000};
        for (int i = 0; i < 5; i++) begin
            cmd(cfgs[i], tgts[i], `IDBP_OP_PAGE, 8'h00, st);
            chk(st[2:1], 2'h3);
        end
        apb(1'b1, 8'h20, 32'hFFFF, st);
        chk(perr, 1'b1);
        apb(1'b0, 8'h20, 32'h0, st);
        chk(st, 32'h0);
    endtask

    initial begin
        repeat (10) @(posedge CLK_SYS_I);
        NRST_I <= 1'b1;
        t_reset();
        t_kinds();
        t_read(4'h0, 1'b0, 5'h03, 4'h3, 8'hC3);
        t_read(4'h0, 1'b1, 5'h08, 4'h8, 8'h3C);
        t_read(4'h5, 1'b0, 5'h0B, 4'h3, 8'h96);
        t_protect();
        t_errors();
        final_report();
    end
endmodule // isa_disk_bank_paging_tb

`default_nettype wire
